// [rtl/i2ct_target.sv]
// Two-wire bus target: address match, register pointer, write strobes and read data
// What this block does
// - Same packet handling at standard, fast, fast-plus and high-speed rates.
// - Clock is input only; data is only ever pulled low.
// - Data pulled low only for read bits and acknowledge.
// - All bytes shifted most significant bit first.
// - Answer only to seven-bit address 0x70.
// - Data changes while clock low; bits sampled on rising clock.
// - Falling data with clock high opens a transaction.
// - Rising data with clock high ends it; bus idles.
// - Read uses register address, repeated start, then address with read flag.
// - High-speed entry is master code 00001xxx after start.
// - Master code is never acknowledged.
// - Repeated start after master code enters high-speed mode.
// - High-speed mode holds until stop; packets split by repeated starts.
// - Interface works regardless of regulator enable state.
// - Accepted bytes acknowledged by holding data low.
// - Not-acknowledge leaves data released.
`default_nettype none
`include "i2ct_regs.svh"
module i2ct_target
	import i2ct_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = `I2CT_TARGET_ADDR
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       scl_clk_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	input  wire logic [7:0] rd_data_in,
	output logic [7:0]      rd_addr_out,
	output logic            wr_valid_out,
	output i2ct_wr_t        wr_out,
	output logic            hs_mode_out,
	output logic            busy_out
);
	// Link side: runs on the bus clock line itself, so bit timing follows the
	// controller at any rate with no oversampling limit.
	// Start and stop are seen as data edges while clock is high; each is held
	// in a flop clocked by the data line, cleared on the next rising clock edge.
	logic start_q;
	logic stop_q;
	logic start_clr_q;
	logic stop_clr_q;

	// Start: data falls, clock high. Cleared from the clock-line domain by toggle compare.
	always_ff @(negedge sda_in or posedge rst_in) begin
		if (rst_in)
			start_q <= 1'b0;
		else if (scl_clk_in)
			start_q <= ~start_clr_q;
	end

	always_ff @(posedge sda_in or posedge rst_in) begin
		if (rst_in)
			stop_q <= 1'b0;
		else if (scl_clk_in)
			stop_q <= ~stop_clr_q;
	end

	logic start_seen;
	logic stop_seen;
	assign start_seen = start_q != start_clr_q;
	assign stop_seen  = stop_q != stop_clr_q;

	i2ct_state_t st_q;
	i2ct_state_t st_d;
	logic [7:0]  sh_q;
	logic [7:0]  sh_d;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [7:0]  ptr_q;
	logic [7:0]  ptr_d;
	logic        ptr_set_q;
	logic        ptr_set_d;
	logic        hs_q;
	logic        hs_d;
	logic        code_q;
	logic        code_d;
	logic        ack_ok_q;
	logic        ack_ok_d;
	logic        wtog_q;
	logic        wtog_d;
	i2ct_wr_t    wbuf_q;
	i2ct_wr_t    wbuf_d;
	logic        stc_d;
	logic        spc_d;

	function automatic logic is_hs_code(input logic [7:0] b);
		is_hs_code = b[7:3] == `I2CT_HS_CODE_TOP;
	endfunction : is_hs_code

	logic [7:0] byte_in;
	assign byte_in = {sh_q[6:0], sda_in};

	// Rising clock edge: sample data bits.
	always_comb begin
		st_d      = st_q;
		sh_d      = sh_q;
		cnt_d     = cnt_q;
		ptr_d     = ptr_q;
		ptr_set_d = ptr_set_q;
		hs_d      = hs_q;
		code_d    = code_q;
		ack_ok_d  = ack_ok_q;
		wtog_d    = wtog_q;
		wbuf_d    = wbuf_q;
		stc_d     = start_clr_q;
		spc_d     = stop_clr_q;
		if (stop_seen) begin
			spc_d  = stop_q;
			hs_d   = 1'b0;
			code_d = 1'b0;
			st_d   = I2CT_IDLE;
		end
		if (start_seen) begin
			stc_d  = start_q;
			// Repeated start after master code switches rate mode.
			if (code_q && !stop_seen)
				hs_d = 1'b1;
			code_d    = 1'b0;
			ptr_set_d = 1'b0;
			sh_d      = {7'h00, sda_in};
			cnt_d     = 4'h1;
			st_d      = I2CT_ADDR;
		end else begin
			case (st_q)
				I2CT_ADDR: begin
					sh_d  = byte_in;
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `I2CT_LAST_BIT) begin
						// Address match or master code.
						ack_ok_d = byte_in[7:1] == TARGET_ADDR;
						code_d   = is_hs_code(byte_in);
						st_d     = I2CT_AACK;
					end
				end
				I2CT_AACK: begin
					cnt_d = 4'h0;
					if (!ack_ok_q)
						st_d = I2CT_IDLE;
					else if (sh_q[0] == `I2CT_RW_READ)
						st_d = I2CT_RDATA;
					else
						st_d = I2CT_WDATA;
				end
				I2CT_WDATA: begin
					sh_d  = byte_in;
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `I2CT_LAST_BIT) begin
						st_d = I2CT_WACK;
						if (!ptr_set_q) begin
							ptr_d     = byte_in;
							ptr_set_d = 1'b1;
						end else begin
							wbuf_d = '{addr: ptr_q, data: byte_in};
							wtog_d = ~wtog_q;
							ptr_d  = ptr_q + 8'h01;
						end
					end
				end
				I2CT_WACK: begin
					cnt_d = 4'h0;
					st_d  = I2CT_WDATA;
				end
				I2CT_RDATA: begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `I2CT_LAST_BIT)
						st_d = I2CT_RACK;
				end
				I2CT_RACK: begin
					cnt_d = 4'h0;
					// Controller acknowledge low means another byte follows.
					ptr_d = ptr_q + 8'h01;
					st_d  = sda_in ? I2CT_IDLE : I2CT_RDATA;
				end
				I2CT_IDLE: st_d = I2CT_IDLE;
				default:   st_d = I2CT_IDLE;
			endcase
		end
	end

	// Link side takes rst_in as an asynchronous clear: the bus clock stands
	// still between frames, so release never lands near a link edge.
	// Nothing here looks at the regulator enable, so shutdown keeps it alive.
	always_ff @(posedge scl_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q        <= I2CT_IDLE;
			sh_q        <= 8'h00;
			cnt_q       <= 4'h0;
			ptr_q       <= 8'h00;
			ptr_set_q   <= 1'b0;
			hs_q        <= 1'b0;
			code_q      <= 1'b0;
			ack_ok_q    <= 1'b0;
			wtog_q      <= 1'b0;
			wbuf_q      <= '0;
			start_clr_q <= 1'b0;
			stop_clr_q  <= 1'b0;
		end else begin
			st_q        <= st_d;
			sh_q        <= sh_d;
			cnt_q       <= cnt_d;
			ptr_q       <= ptr_d;
			ptr_set_q   <= ptr_set_d;
			hs_q        <= hs_d;
			code_q      <= code_d;
			ack_ok_q    <= ack_ok_d;
			wtog_q      <= wtog_d;
			wbuf_q      <= wbuf_d;
			start_clr_q <= stc_d;
			stop_clr_q  <= spc_d;
		end
	end

	// Drive phase: change data only after the falling clock edge.
	logic [7:0] rd_sh_q;
	logic [7:0] rd_sh_d;
	logic [7:0] rd_cur;
	logic       pull_d;

	// The first drive slot of each read byte takes the word straight from the
	// register file: the pointer moved half a bit earlier, so it has settled.
	always_comb begin
		rd_cur  = (cnt_q == 4'h0) ? rd_data_in : rd_sh_q;
		rd_sh_d = rd_sh_q;
		pull_d  = 1'b0;
		case (st_q)
			I2CT_AACK:  pull_d = ack_ok_q && !start_seen && !stop_seen;
			I2CT_WACK:  pull_d = 1'b1;
			I2CT_RDATA: begin
				pull_d  = ~rd_cur[7];
				rd_sh_d = {rd_cur[6:0], 1'b1};
			end
			default:    pull_d = 1'b0;
		endcase
	end

	// Enter of ack/data cycles happens at posedge; the pull is applied at the
	// next negedge so data never moves while clock is high.
	logic pull_neg_q;
	always_ff @(negedge scl_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_sh_q    <= 8'h00;
			pull_neg_q <= 1'b0;
		end else begin
			rd_sh_q    <= rd_sh_d;
			pull_neg_q <= pull_d;
		end
	end

	// Open-drain: output level is always low, only the enable moves.
	always_ff @(posedge clk_in) begin
		sda_out <= 1'b0;
	end

	logic pull_s;
	i2ct_sync #(.WIDTH(1)) u_pull_sync (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.async_in     (pull_neg_q),
		.reset_val_in (1'b0),
		.sync_out     (pull_s)
	);
	// Release wins on reset; otherwise the enable follows the synchronised pull.
	always_ff @(posedge clk_in) begin
		if (rst_in)
			sda_oe_out <= 1'b0;
		else
			sda_oe_out <= pull_s;
	end

	// Toggle crossing for write strobes; data is held stable since the toggle.
	// Start and stop flags cross as well, so busy and rate mode follow a stop
	// although no link clock edge comes after it.
	logic [4:0] lnk_s;
	logic       wtog_last_q;
	i2ct_sync #(.WIDTH(5)) u_st_sync (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.async_in     ({wtog_q, hs_q, st_q != I2CT_IDLE, start_seen, stop_seen}),
		.reset_val_in (5'h00),
		.sync_out     (lnk_s)
	);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wtog_last_q  <= 1'b0;
			wr_valid_out <= 1'b0;
			wr_out       <= '0;
			hs_mode_out  <= 1'b0;
			busy_out     <= 1'b0;
			rd_addr_out  <= 8'h00;
		end else begin
			wtog_last_q  <= lnk_s[4];
			wr_valid_out <= lnk_s[4] != wtog_last_q;
			if (lnk_s[4] != wtog_last_q)
				wr_out <= wbuf_q;
			hs_mode_out  <= lnk_s[3] && !lnk_s[0];
			busy_out     <= (lnk_s[2] && !lnk_s[0]) || lnk_s[1];
			rd_addr_out  <= ptr_q;
		end
	end
endmodule : i2ct_target
`default_nettype wire

// [shared/i2ct_regs.svh]
// Constants for the two-wire target interface
`ifndef I2CT_REGS_SVH
`define I2CT_REGS_SVH

`define I2CT_TARGET_ADDR   7'h70
`define I2CT_HS_CODE_TOP   5'h01
`define I2CT_BITS_PER_BYTE 4'h8
`define I2CT_LAST_BIT      4'h7
`define I2CT_RW_READ       1'b1

`endif

// [shared/i2ct_pkg.sv]
// Types shared by the two-wire target interface
`default_nettype none
package i2ct_pkg;

	typedef enum logic [6:0] {
		I2CT_IDLE  = 7'h01,
		I2CT_ADDR  = 7'h02,
		I2CT_AACK  = 7'h04,
		I2CT_WDATA = 7'h08,
		I2CT_WACK  = 7'h10,
		I2CT_RDATA = 7'h20,
		I2CT_RACK  = 7'h40
	} i2ct_state_t;

	// Write strobe toward the register file
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} i2ct_wr_t;

	// Line events seen on the link clock domain side
	typedef struct packed {
		logic start;
		logic stop;
	} i2ct_cond_t;

endpackage : i2ct_pkg
`default_nettype wire

// [rtl/i2ct_sync.sv]
// Two-flop synchroniser for a level crossing into clk_in
`default_nettype none
module i2ct_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_val_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	// Both stages load the reset value so nothing unknown leaves during reset
	always_comb begin
		meta_d = rst_in ? reset_val_in : async_in;
		sync_d = rst_in ? reset_val_in : meta_q;
	end

	always_ff @(posedge clk_in) begin
		meta_q   <= meta_d;
		sync_out <= sync_d;
	end
endmodule : i2ct_sync
`default_nettype wire

// [bench/i2ct_target_sva.sv]
// Port assertions for the two-wire target
`default_nettype none
module i2ct_target_sva
	import i2ct_pkg::*;
(
	input wire logic     clk_in,
	input wire logic     rst_in,
	input wire logic     scl_clk_in,
	input wire logic     sda_in,
	input wire logic     sda_out,
	input wire logic     sda_oe_out,
	input wire logic     wr_valid_out,
	input wire i2ct_wr_t wr_out,
	input wire logic     hs_mode_out,
	input wire logic     busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_only_pull_low: assert property (!sda_out) else $error("data driven high");
	a_pull_scl_low: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
		else $error("pull changed while clock high");
	a_idle_no_pull: assert property (!busy_out |-> !sda_oe_out) else $error("pull outside frame");
	a_start_sets_busy: assert property (scl_clk_in && $fell(sda_in) |-> ##[1:10] busy_out)
		else $error("start not seen");
	a_stop_ends_busy: assert property (scl_clk_in && $rose(sda_in) |-> ##[1:10] !busy_out)
		else $error("stop not seen");
	a_stop_ends_hs: assert property (scl_clk_in && $rose(sda_in) |-> ##[1:10] !hs_mode_out)
		else $error("fast mode kept after stop");
	a_wr_one_pulse: assert property (wr_valid_out |=> !wr_valid_out) else $error("write pulse too long");
	a_wr_data_held: assert property ($changed(wr_out) |-> wr_valid_out) else $error("write data moved");
endmodule : i2ct_target_sva
bind i2ct_target i2ct_target_sva chk_u (.*);
`default_nettype wire

// [bench/i2ct_host_model.sv]
// Behavioural bus controller on the far side of the target
`default_nettype none
module i2ct_host_model (
	output var logic  scl_out,
	output var logic  pull_low_out,
	input  wire logic sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock stands high between frames
	initial begin
		scl_out = 1'b1;
		pull_low_out = 1'b0;
	end
	task start_cond;
		pull_low_out = 1'b0;
		#12 scl_out = 1'b1;
		#12 pull_low_out = 1'b1;
		#12 scl_out = 1'b0;
		#12;
	endtask : start_cond
	task stop_cond;
		pull_low_out = 1'b1;
		#12 scl_out = 1'b1;
		#12 pull_low_out = 1'b0;
		#24;
	endtask : stop_cond
	task bit_slot(input logic tx, output logic rx);
		pull_low_out = !tx;
		#12 scl_out = 1'b1;
		rx = sda_in;
		#24 scl_out = 1'b0;
		#12;
	endtask : bit_slot
	task xfer(input logic [7:0] tx, input logic host_ack, output logic [7:0] rx, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(tx[i], s);
			rx[i] = s;
		end
		bit_slot(!host_ack, s);
		acked = !s;
	endtask : xfer
endmodule : i2ct_host_model
`default_nettype wire

// [bench/i2ct_target_tb_top.sv]
// Self-checking bench for the two-wire target
`default_nettype none
module i2ct_target_tb_top;
	import i2ct_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0, rst_in = 1'b0, scl, host_low, sda_o, sda_oe, wr_valid, hs, busy, ak;
	logic [7:0] rd_data = 8'h00, rd_addr, rx;
	i2ct_wr_t wr_o, wr_seen;
	wire logic sda_line = !(host_low || sda_oe);
	int n_fail = 0, cmp_count = 0, n_wr = 0;
	logic [7:0] rows [4][2] = '{'{8'h00, 8'h01}, '{8'h01, 8'h47}, '{8'h02, 8'h0c}, '{8'hff, 8'hff}};
	logic [7:0] hs_codes [2] = '{8'h08, 8'h0f};
	always #2 clk_in = ~clk_in;
	i2ct_target dut_u (.clk_in(clk_in), .rst_in(rst_in), .scl_clk_in(scl), .sda_in(sda_line), .sda_out(sda_o),
		.sda_oe_out(sda_oe), .rd_data_in(rd_data), .rd_addr_out(rd_addr), .wr_valid_out(wr_valid),
		.wr_out(wr_o), .hs_mode_out(hs), .busy_out(busy));
	i2ct_host_model host_u (.scl_out(scl), .pull_low_out(host_low), .sda_in(sda_line));
	// Register file stand-in: contents are the pointer scrambled
	always @(posedge clk_in) begin
		rd_data <= rd_addr ^ 8'h5a;
		if (wr_valid) begin
			wr_seen <= wr_o;
			n_wr <= n_wr + 1;
		end
	end
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task wait_wr(input int target);
		for (int i = 0; i < 64 && n_wr < target; i++)
			@(posedge clk_in);
		if (n_wr < target) begin
			n_fail++;
			complete_run();
		end
	endtask : wait_wr
	task wr_body(input logic [7:0] r, input logic [7:0] d);
		host_u.xfer(8'he0, 1'b0, rx, ak);
		check("addr ack", ak, 1'b1);
		host_u.xfer(r, 1'b0, rx, ak);
		check("ptr ack", ak, 1'b1);
		host_u.xfer(d, 1'b0, rx, ak);
		check("data ack", ak, 1'b1);
	endtask : wr_body
	initial begin
		// Raised just after time zero so the link side sees a reset edge
		rst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		check("idle outs", {sda_o, sda_oe, wr_valid, hs, busy}, 5'h00);
		for (int i = 0; i < 4; i++) begin
			host_u.start_cond();
			wr_body(rows[i][0], rows[i][1]);
			host_u.stop_cond();
			wait_wr(i + 1);
			check("write", wr_seen, {rows[i][0], rows[i][1]});
			host_u.start_cond();
			host_u.xfer(8'he0, 1'b0, rx, ak);
			host_u.xfer(rows[i][0], 1'b0, rx, ak);
			host_u.start_cond();
			host_u.xfer(8'he1, 1'b0, rx, ak);
			check("read ack", ak, 1'b1);
			host_u.xfer(8'hff, 1'b1, rx, ak);
			check("read 0", rx, rows[i][0] ^ 8'h5a);
			host_u.xfer(8'hff, 1'b0, rx, ak);
			check("read 1", rx, 8'(rows[i][0] + 8'h01) ^ 8'h5a);
			host_u.stop_cond();
		end
		host_u.start_cond();
		host_u.xfer(8'he2, 1'b0, rx, ak);
		check("foreign ack", ak, 1'b0);
		host_u.xfer(8'h00, 1'b0, rx, ak);
		check("ignored ack", ak, 1'b0);
		host_u.stop_cond();
		for (int i = 0; i < 2; i++) begin
			host_u.start_cond();
			host_u.xfer(hs_codes[i], 1'b0, rx, ak);
			check("code ack", ak, 1'b0);
			host_u.start_cond();
			wr_body(8'h02, hs_codes[i]);
			check("fast on", hs, 1'b1);
			host_u.start_cond();
			host_u.xfer(8'he0, 1'b0, rx, ak);
			check("fast kept", {hs, ak}, 2'h3);
			host_u.stop_cond();
			wait_wr(5 + i);
			check("fast write", wr_seen, {8'h02, hs_codes[i]});
		end
		complete_run();
	end
endmodule : i2ct_target_tb_top
`default_nettype wire
